// ---- phyan_ctrl.sv ----
// negotiation, crossover and loopback control of a 10/100/1000 transceiver
// What this block does
// - pick best technology both ends advertise
// - at gigabit, resolve master favouring multiport
// - advertise pause bits 10,11 from register 0x04
// - store partner pause bits in register 0x05
// - next page content sent from register 0x07
// - parallel detect from 10/100 link signals
// - parallel detect loads bits 5,7, selector 00001
// - expansion bit 0 zero after parallel detect
// - parallel detect fault sets on bad link
// - lost negotiated link resumes negotiation
// - control bit 9 restarts negotiation
// - restart silences link until break timer ends
// - strap-disabled negotiation stays disabled
// - negotiation not done within about three seconds restarts with a break
// - crossover resolved before pulse exchange starts
// - crossover auto by strap or bit 6
// - forced mapping by strap or bit 5
// - crossover runs with negotiation on or off
// - MII loop in 0x00, others in 0x16
// - loop availability and link status per speed
`timescale 1ns/100ps
module phyan_ctrl
    import phyan_pkg::*;
#(
    parameter int BREAK_CYCLES = BREAK_LINK_CYCLES,
    parameter int AN_MAX = AN_MAX_CYCLES,
    parameter int XOVER_SLOT = XOVER_SLOT_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // straps, caught after reset release
    input wire logic strap_an_off,
    input wire logic crossover_auto_off_strap,
    input wire logic crossover_forced_strap,
    // management register port
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_q,
    // local station abilities
    input wire logic local_gig_adv,
    input wire logic local_multiport,
    input wire logic [10:0] local_seed,
    // link partner side
    input wire logic partner_page_valid,
    input wire logic [15:0] partner_page,
    input wire logic partner_gig_adv,
    input wire logic partner_multiport,
    input wire logic [10:0] partner_seed,
    input wire logic pd_link_10,
    input wire logic pd_link_100,
    input wire logic link_good,
    input wire logic signal_detect,
    // line control
    output logic flp_tx_q,
    output logic [15:0] tx_page_q,
    output logic data_tx_en_q,
    output logic crossed_q,
    // resolved mode
    output phyan_speed_type speed_q,
    output logic full_duplex_q,
    output logic master_q,
    output logic link_up_q,
    output logic link_ind_q,
    // loopback selects
    output logic mii_loop_q,
    output logic pcs_loop_q,
    output logic dig_loop_q,
    output logic ana_loop_q,
    output logic rev_loop_q
);
    phyan_state_type an_state_q, an_state_d;
    logic init_q, an_locked_q, pd_done_q, link_seen_q;
    logic [15:0] ctrl_q, adv_q, partner_q, np_q, psc_q, st_q;
    logic exp_partner_q, exp_page_q, exp_fault_q;
    logic wr_ctrl, restart_req, an_en_new, tmr_start, tmr_done, xover_done;
    logic pd_single, pd_fault_ev;
    logic [31:0] tmr_load;
    logic [3:0] res;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction

    // {valid, speed, full duplex}, best common technology first
    function automatic logic [3:0] resolve(input logic [15:0] l, input logic [15:0] p,
                                           input logic lg, input logic pg);
        if (lg && pg) return {1'b1, SPD_1000, 1'b1};
        if (l[ADV_100FD] && p[ADV_100FD]) return {1'b1, SPD_100, 1'b1};
        if (l[ADV_100HD] && p[ADV_100HD]) return {1'b1, SPD_100, 1'b0};
        if (l[ADV_10FD] && p[ADV_10FD]) return {1'b1, SPD_10, 1'b1};
        if (l[ADV_10HD] && p[ADV_10HD]) return {1'b1, SPD_10, 1'b0};
        return {1'b0, SPD_10, 1'b0};
    endfunction

    assign wr_ctrl = reg_wr && hit(reg_addr, REG_BASIC_CONTROL);
    assign an_en_new = reg_wdata[BC_AN_EN] && !an_locked_q;
    // restart bit, or enable going from clear to set
    assign restart_req = wr_ctrl && an_en_new
                         && (reg_wdata[BC_RESTART] || !ctrl_q[BC_AN_EN]);
    assign pd_single = (pd_link_10 ^ pd_link_100) && !partner_page_valid;
    assign pd_fault_ev = (an_state_q == AN_ABILITY && pd_link_10 && pd_link_100)
                         || (an_state_q == AN_DONE && pd_done_q && !link_good);
    assign res = resolve(adv_q, partner_q, local_gig_adv, partner_gig_adv);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            init_q <= 1'b0;
        end else begin
            init_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            an_locked_q <= 1'b0;
        end else if (!init_q) begin
            an_locked_q <= strap_an_off;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= BC_RESET;
        end else if (!init_q) begin
            ctrl_q[BC_AN_EN] <= !strap_an_off;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata;
            ctrl_q[BC_RESTART] <= 1'b0;
            ctrl_q[BC_AN_EN] <= an_en_new;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            adv_q <= ADV_RESET;
            np_q <= NP_RESET;
            st_q <= ST_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, REG_LOCAL_ABILITY_ADVERT)) adv_q <= reg_wdata;
            if (hit(reg_addr, REG_NEXT_PAGE_TRANSMIT)) np_q <= reg_wdata;
            if (hit(reg_addr, REG_SELFTEST_LOOP_CONTROL)) st_q <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            psc_q <= PSC_RESET;
        end else if (!init_q) begin
            psc_q[PSC_AUTO_XOVER] <= !crossover_auto_off_strap;
            psc_q[PSC_FORCE_XOVER] <= crossover_forced_strap;
        end else if (reg_wr && hit(reg_addr, REG_PHY_SPECIFIC_CONTROL)) begin
            psc_q <= reg_wdata;
        end
    end

    // negotiation sequencing
    always_comb begin
        an_state_d = an_state_q;
        if (!init_q) begin
            an_state_d = AN_OFF;
        end else if (restart_req) begin
            an_state_d = AN_BREAK;
        end else if (!ctrl_q[BC_AN_EN]) begin
            an_state_d = AN_OFF;
        end else begin
            unique case (an_state_q)
                AN_OFF: an_state_d = AN_BREAK;
                AN_BREAK: if (tmr_done) an_state_d = AN_ABILITY;
                AN_ABILITY: begin
                    if (partner_page_valid) begin
                        an_state_d = (adv_q[ADV_NEXT_PAGE] && partner_page[ADV_NEXT_PAGE])
                                     ? AN_NEXT : AN_DONE;
                    end else if (pd_single) begin
                        an_state_d = AN_DONE;
                    end else if (tmr_done) begin
                        an_state_d = AN_BREAK;
                    end
                end
                AN_NEXT: begin
                    if (partner_page_valid && !np_q[ADV_NEXT_PAGE]
                        && !partner_page[ADV_NEXT_PAGE]) begin
                        an_state_d = AN_DONE;
                    end else if (tmr_done) begin
                        an_state_d = AN_BREAK;
                    end
                end
                AN_DONE: if (link_seen_q && !link_good) an_state_d = AN_ABILITY;
                default: an_state_d = AN_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            an_state_q <= AN_OFF;
        end else begin
            an_state_q <= an_state_d;
        end
    end

    assign tmr_start = (an_state_d != an_state_q || restart_req)
                       && (an_state_d == AN_BREAK || an_state_d == AN_ABILITY);
    assign tmr_load = (an_state_d == AN_BREAK) ? 32'(BREAK_CYCLES) : 32'(AN_MAX);

    phyan_timer #(.W(32)) u_timer (
        .mclk(mclk),
        .reset(reset),
        .start(tmr_start),
        .load(tmr_load),
        .done_q(tmr_done)
    );

    // runs whatever the negotiation state
    phyan_xover #(.SLOT(XOVER_SLOT)) u_xover (
        .mclk(mclk),
        .reset(reset),
        .auto_en(psc_q[PSC_AUTO_XOVER]),
        .force_cross(psc_q[PSC_FORCE_XOVER]),
        .signal_ok(signal_detect),
        .restart(an_state_d == AN_BREAK && an_state_q != AN_BREAK),
        .cross_q(crossed_q),
        .done_q(xover_done)
    );

    // partner page capture and parallel detect result
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            partner_q <= '0;
            pd_done_q <= 1'b0;
        end else if (an_state_q == AN_ABILITY && partner_page_valid) begin
            partner_q <= partner_page;
            pd_done_q <= 1'b0;
        end else if (an_state_q == AN_ABILITY && pd_single) begin
            partner_q <= '0;
            partner_q[ADV_100HD] <= pd_link_100;
            partner_q[ADV_10HD] <= pd_link_10;
            partner_q[4:0] <= SEL_8023;
            pd_done_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link_seen_q <= 1'b0;
        end else begin
            link_seen_q <= an_state_q == AN_DONE && (link_seen_q || link_good);
        end
    end

    // expansion flags; a new event beats a read clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            exp_partner_q <= 1'b0;
            exp_page_q <= 1'b0;
            exp_fault_q <= 1'b0;
        end else begin
            if (an_state_q == AN_ABILITY && partner_page_valid) begin
                exp_partner_q <= 1'b1;
            end else if (an_state_d == AN_BREAK || (an_state_q == AN_ABILITY && pd_single)) begin
                exp_partner_q <= 1'b0;
            end
            if (partner_page_valid && (an_state_q == AN_ABILITY || an_state_q == AN_NEXT)) begin
                exp_page_q <= 1'b1;
            end else if (reg_rd && hit(reg_addr, REG_NEGOTIATION_EXPANSION)) begin
                exp_page_q <= 1'b0;
            end
            if (pd_fault_ev) begin
                exp_fault_q <= 1'b1;
            end else if (reg_rd && hit(reg_addr, REG_NEGOTIATION_EXPANSION)) begin
                exp_fault_q <= 1'b0;
            end
        end
    end

    // line control
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flp_tx_q <= 1'b0;
            tx_page_q <= '0;
            data_tx_en_q <= 1'b0;
        end else begin
            flp_tx_q <= (an_state_q == AN_ABILITY || an_state_q == AN_NEXT)
                        && xover_done;
            tx_page_q <= (an_state_q == AN_NEXT) ? np_q : adv_q;
            data_tx_en_q <= an_state_q == AN_DONE || an_state_q == AN_OFF;
        end
    end

    // resolved speed, duplex and role
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            speed_q <= SPD_10;
            full_duplex_q <= 1'b0;
            master_q <= 1'b0;
        end else if (an_state_q == AN_OFF) begin
            speed_q <= ctrl_q[BC_SPEED_MSB] ? SPD_1000
                       : (ctrl_q[BC_SPEED_LSB] ? SPD_100 : SPD_10);
            full_duplex_q <= ctrl_q[BC_DUPLEX];
            master_q <= local_multiport;
        end else if (an_state_q == AN_DONE) begin
            if (pd_done_q) begin
                speed_q <= partner_q[ADV_100HD] ? SPD_100 : SPD_10;
                full_duplex_q <= 1'b0;
            end else begin
                speed_q <= phyan_speed_type'(res[2:1]);
                full_duplex_q <= res[0];
            end
            if (local_multiport != partner_multiport) begin
                master_q <= local_multiport;
            end else begin
                master_q <= local_seed > partner_seed;
            end
        end
    end

    // loopback selects and link indication
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link_up_q <= 1'b0;
            link_ind_q <= 1'b0;
            mii_loop_q <= 1'b0;
            pcs_loop_q <= 1'b0;
            dig_loop_q <= 1'b0;
            ana_loop_q <= 1'b0;
            rev_loop_q <= 1'b0;
        end else begin
            link_up_q <= link_good && (an_state_q == AN_DONE || an_state_q == AN_OFF);
            link_ind_q <= link_up_q && !ctrl_q[BC_MII_LOOP]
                          && !(pcs_loop_q && speed_q != SPD_100);
            mii_loop_q <= ctrl_q[BC_MII_LOOP];
            pcs_loop_q <= st_q[ST_PCS_LOOP] && speed_q != SPD_10;
            dig_loop_q <= st_q[ST_DIG_LOOP];
            ana_loop_q <= st_q[ST_ANA_LOOP];
            rev_loop_q <= st_q[ST_REV_LOOP];
        end
    end

    // register read port, answer one cycle after the strobe
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_BASIC_CONTROL: reg_rdata_q <= ctrl_q;
                REG_BASIC_STATUS: reg_rdata_q <= BS_CAPS
                    | (16'(an_state_q == AN_DONE) << BS_AN_DONE)
                    | (16'(link_ind_q) << BS_LINK);
                REG_LOCAL_ABILITY_ADVERT: reg_rdata_q <= adv_q;
                REG_PARTNER_ABILITY: reg_rdata_q <= partner_q;
                REG_NEGOTIATION_EXPANSION: reg_rdata_q <= (16'(exp_fault_q) << EXP_PD_FAULT)
                    | (16'(exp_page_q) << EXP_PAGE_RX)
                    | (16'(exp_partner_q) << EXP_PARTNER_AN);
                REG_NEXT_PAGE_TRANSMIT: reg_rdata_q <= np_q;
                REG_PHY_SPECIFIC_CONTROL: reg_rdata_q <= psc_q;
                REG_SELFTEST_LOOP_CONTROL: reg_rdata_q <= st_q;
                default: reg_rdata_q <= '0;
            endcase
        end
    end

    chk_restart_break: assert property (@(posedge mclk) disable iff (reset)
        restart_req && init_q |=> an_state_q == AN_BREAK)
        else $error("restart did not enter break");
    chk_break_quiet: assert property (@(posedge mclk) disable iff (reset)
        an_state_q == AN_BREAK ##1 an_state_q == AN_BREAK |-> !flp_tx_q && !data_tx_en_q)
        else $error("line active during break");
    chk_flp_after_xover: assert property (@(posedge mclk) disable iff (reset)
        $rose(flp_tx_q) |-> $past(xover_done))
        else $error("pulses before crossover resolved");
    chk_strap_lock: assert property (@(posedge mclk) disable iff (reset)
        an_locked_q && init_q |=> !ctrl_q[BC_AN_EN] && an_state_q == AN_OFF)
        else $error("strap-disabled negotiation came back");
    chk_pd_selector: assert property (@(posedge mclk) disable iff (reset)
        an_state_q == AN_ABILITY && pd_single && !restart_req && ctrl_q[BC_AN_EN]
        |=> partner_q[4:0] == SEL_8023 && an_state_q == AN_DONE && !exp_partner_q)
        else $error("parallel detect result wrong");
    chk_pd_fault_set: assert property (@(posedge mclk) disable iff (reset)
        pd_fault_ev |=> exp_fault_q)
        else $error("parallel detect fault missed");
    chk_pause_adv: assert property (@(posedge mclk) disable iff (reset)
        an_state_q == AN_ABILITY |=> tx_page_q[11:10] == $past(adv_q[11:10]))
        else $error("pause advertisement not sent");
    chk_lost_resume: assert property (@(posedge mclk) disable iff (reset)
        an_state_q == AN_DONE && link_seen_q && !link_good && !restart_req
        && ctrl_q[BC_AN_EN] |=> an_state_q == AN_ABILITY)
        else $error("lost link did not resume negotiation");
    chk_pcs_speed: assert property (@(posedge mclk) disable iff (reset)
        pcs_loop_q |-> $past(speed_q) != SPD_10)
        else $error("coding loop at 10M");
    chk_mii_no_link: assert property (@(posedge mclk) disable iff (reset)
        $past(mii_loop_q) && mii_loop_q |-> !link_ind_q)
        else $error("link shown in MAC-side loop");
endmodule

// ---- phyan_pkg.sv ----
// constants, offsets and types shared by the negotiation control block
package phyan_pkg;
    // register offsets on the management port
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] REG_LOCAL_ABILITY_ADVERT = 5'h04;
    localparam logic [4:0] REG_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] REG_NEGOTIATION_EXPANSION = 5'h06;
    localparam logic [4:0] REG_NEXT_PAGE_TRANSMIT = 5'h07;
    localparam logic [4:0] REG_PHY_SPECIFIC_CONTROL = 5'h10;
    localparam logic [4:0] REG_SELFTEST_LOOP_CONTROL = 5'h16;
    // basic_control fields
    localparam int BC_MII_LOOP = 14;
    localparam int BC_SPEED_LSB = 13;
    localparam int BC_AN_EN = 12;
    localparam int BC_RESTART = 9;
    localparam int BC_DUPLEX = 8;
    localparam int BC_SPEED_MSB = 6;
    // basic_status fields
    localparam int BS_AN_DONE = 5;
    localparam int BS_LINK = 2;
    // advertisement and partner page fields
    localparam int ADV_NEXT_PAGE = 15;
    localparam int ADV_ASYM_PAUSE = 11;
    localparam int ADV_PAUSE = 10;
    localparam int ADV_100FD = 8;
    localparam int ADV_100HD = 7;
    localparam int ADV_10FD = 6;
    localparam int ADV_10HD = 5;
    localparam logic [4:0] SEL_8023 = 5'h01;
    // negotiation_expansion fields
    localparam int EXP_PARTNER_AN = 0;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_PD_FAULT = 4;
    // phy_specific_control fields
    localparam int PSC_AUTO_XOVER = 6;
    localparam int PSC_FORCE_XOVER = 5;
    // selftest_loop_control fields
    localparam int ST_PCS_LOOP = 1;
    localparam int ST_DIG_LOOP = 2;
    localparam int ST_ANA_LOOP = 3;
    localparam int ST_REV_LOOP = 4;
    // values after reset
    localparam logic [15:0] BC_RESET = 16'h1140;
    localparam logic [15:0] BS_CAPS = 16'h7908;
    localparam logic [15:0] ADV_RESET = 16'h01E1;
    localparam logic [15:0] NP_RESET = 16'h2001;
    localparam logic [15:0] PSC_RESET = 16'h0040;
    localparam logic [15:0] ST_RESET = 16'h0000;
    // timing
    localparam int CLK_KHZ = 250000;
    localparam int BREAK_LINK_MS = 1200;
    localparam int AN_MAX_MS = 3000;
    localparam int XOVER_SLOT_MS = 60;
    localparam int BREAK_LINK_CYCLES = BREAK_LINK_MS * CLK_KHZ;
    localparam int AN_MAX_CYCLES = AN_MAX_MS * CLK_KHZ;
    localparam int XOVER_SLOT_CYCLES = XOVER_SLOT_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        SPD_10 = 2'b00,
        SPD_100 = 2'b01,
        SPD_1000 = 2'b10
    } phyan_speed_type;

    typedef enum logic [2:0] {
        AN_OFF = 3'b000,
        AN_BREAK = 3'b001,
        AN_ABILITY = 3'b011,
        AN_NEXT = 3'b010,
        AN_DONE = 3'b110
    } phyan_state_type;
endpackage

// ---- phyan_timer.sv ----
// one-shot down counter with a sticky done flag
`timescale 1ns/100ps
module phyan_timer #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic [W-1:0] load,
    // status
    output logic done_q
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (start) begin
            cnt_q <= load;
            done_q <= 1'b0;
        end else if (cnt_q > W'(1)) begin
            cnt_q <= cnt_q - W'(1);
        end else if (cnt_q == W'(1)) begin
            cnt_q <= '0;
            done_q <= 1'b1;
        end
    end
endmodule

// ---- phyan_xover.sv ----
// straight or crossed channel mapping, automatic or forced
`timescale 1ns/100ps
module phyan_xover #(
    parameter int SLOT = 32'd15000000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control
    input wire logic auto_en,
    input wire logic force_cross,
    input wire logic signal_ok,
    input wire logic restart,
    // result
    output logic cross_q,
    output logic done_q
);
    logic [31:0] slot_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cross_q <= 1'b0;
            done_q <= 1'b0;
            slot_q <= '0;
        end else if (!auto_en) begin
            cross_q <= force_cross;
            done_q <= 1'b1;
            slot_q <= '0;
        end else if (restart) begin
            done_q <= 1'b0;
            slot_q <= '0;
        end else if (signal_ok) begin
            done_q <= 1'b1;
        end else if (!done_q) begin
            // hunt: flip the pair mapping every slot until energy is seen
            if (slot_q >= 32'(SLOT - 1)) begin
                slot_q <= '0;
                cross_q <= !cross_q;
            end else begin
                slot_q <= slot_q + 32'd1;
            end
        end
    end
endmodule

// ---- phyan_partner.sv ----
// link partner answering each pulse burst with one base page
`timescale 1ns/100ps
module phyan_partner (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // line from the block
    input wire logic flp_tx_q,
    input wire logic enable,
    input wire logic [3:0] delay,
    input wire logic [15:0] page_in,
    // page towards the block
    output logic partner_page_valid,
    output logic [15:0] partner_page
);
    logic [3:0] wait_q;
    logic sent_q;
    // idle page lines never hold the last word
    assign partner_page = partner_page_valid ? page_in : ~page_in;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wait_q <= 4'h0;
            sent_q <= 1'b0;
            partner_page_valid <= 1'b0;
        end else begin
            partner_page_valid <= 1'b0;
            if (!flp_tx_q) begin
                wait_q <= 4'h0;
                sent_q <= 1'b0;
            end else if (enable && !sent_q) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q == delay) begin
                    partner_page_valid <= 1'b1;
                    sent_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- phyan_ctrl_tb.sv ----
// bench for the negotiation control block
`timescale 1ns/100ps
module phyan_ctrl_tb;
    import phyan_pkg::*;
    logic mclk = 0, reset = 1, strap_an_off = 0, crossover_auto_off_strap = 0;
    logic crossover_forced_strap = 0, reg_wr = 0, reg_rd = 0, pen = 1;
    logic [4:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata_q, partner_page, tx_page_q, v;
    logic local_gig_adv = 0, local_multiport = 0, partner_gig_adv = 0, partner_multiport = 0;
    logic [10:0] local_seed = 11'h001, partner_seed = 11'h002;
    logic partner_page_valid, pd_link_10 = 0, pd_link_100 = 0, link_good = 1, signal_detect = 1;
    logic flp_tx_q, data_tx_en_q, crossed_q, full_duplex_q, master_q, link_up_q, link_ind_q;
    logic mii_loop_q, pcs_loop_q, dig_loop_q, ana_loop_q, rev_loop_q;
    logic [3:0] lp_delay = 4'h1;
    phyan_speed_type speed_q;
    int errors = 0, samples_checked = 0, i;
    always #2 mclk = ~mclk;
    phyan_ctrl #(.BREAK_CYCLES(20), .AN_MAX(200), .XOVER_SLOT(8)) u_dut (.*);
    phyan_partner u_lp (.mclk(mclk), .reset(reset), .flp_tx_q(flp_tx_q), .enable(pen),
        .delay(lp_delay), .page_in(16'h0DE1), .partner_page_valid(partner_page_valid),
        .partner_page(partner_page));
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge mclk);
        reg_wr = 0;
    endtask
    task rd(input logic [4:0] a);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge mclk);
        reg_rd = 0;
        v = reg_rdata_q;
    endtask
    task wait_up;
        for (i = 0; i < 2000 && data_tx_en_q !== 1'b1; i++) @(negedge mclk);
        chk("data_up", 16'h0001, {15'h0, data_tx_en_q});
    endtask
    task do_reset;
        reset = 1;
        repeat (20) @(negedge mclk);
        reset = 0;
    endtask
    task end_of_test;
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task t_reset_pause;
        rd(REG_BASIC_CONTROL);
        chk("control", BC_RESET, v);
        rd(5'h02);
        chk("unmapped", 16'h0000, v);
        wr(REG_LOCAL_ABILITY_ADVERT, 16'h0DE1);
        rd(REG_LOCAL_ABILITY_ADVERT);
        chk("advert", 16'h0DE1, v);
        wait_up();
        rd(REG_PARTNER_ABILITY);
        chk("partner", 16'h0DE1, v);
        chk("partner_pause", 16'h0003, {14'h0, v[11:10]});
        chk("tx_page", 16'h0DE1, tx_page_q);
        rd(REG_NEGOTIATION_EXPANSION);
        chk("exp_bit0", 16'h0001, {15'h0, v[0]});
        rd(REG_BASIC_STATUS);
        chk("an_done", 16'h0001, {15'h0, v[5]});
        chk("speed", {14'h0, SPD_100}, {14'h0, speed_q});
        chk("duplex", 16'h0001, {15'h0, full_duplex_q});
    endtask
    task t_restart_gig;
        local_gig_adv = 1;
        partner_gig_adv = 1;
        partner_multiport = 1;
        lp_delay = 4'h9;
        wr(REG_BASIC_CONTROL, 16'h1340);
        repeat (2) @(negedge mclk);
        chk("silent", 16'h0000, {14'h0, flp_tx_q, data_tx_en_q});
        wait_up();
        chk("speed_gig", {14'h0, SPD_1000}, {14'h0, speed_q});
        chk("master", 16'h0000, {15'h0, master_q});
        link_good = 0;
        repeat (3) @(negedge mclk);
        chk("resume", 16'h0001, {15'h0, flp_tx_q});
        link_good = 1;
        wait_up();
    endtask
    task t_parallel;
        pen = 0;
        pd_link_100 = 1;
        wr(REG_BASIC_CONTROL, 16'h1340);
        repeat (2) @(negedge mclk);
        wait_up();
        rd(REG_PARTNER_ABILITY);
        chk("pd_partner", 16'h0081, v);
        rd(REG_NEGOTIATION_EXPANSION);
        chk("pd_exp_bit0", 16'h0000, {15'h0, v[0]});
        chk("pd_speed", {14'h0, SPD_100}, {14'h0, speed_q});
        pd_link_10 = 1;
        wr(REG_BASIC_CONTROL, 16'h1340);
        for (int k = 0; k < 80 && v[4] !== 1'b1; k++) rd(REG_NEGOTIATION_EXPANSION);
        chk("pd_fault", 16'h0001, {15'h0, v[4]});
        pd_link_10 = 0;
        pen = 1;
    endtask
    task t_loop;
        wr(REG_PHY_SPECIFIC_CONTROL, 16'h0000);
        wr(REG_SELFTEST_LOOP_CONTROL, 16'h0004);
        wr(REG_BASIC_CONTROL, 16'h4140);
        repeat (3) @(negedge mclk);
        chk("loops", 16'h0003, {14'h0, dig_loop_q, mii_loop_q});
        chk("mii_link", 16'h0002, {14'h0, link_up_q, link_ind_q});
        wr(REG_SELFTEST_LOOP_CONTROL, 16'h001A);
        wr(REG_BASIC_CONTROL, 16'h0140);
        repeat (3) @(negedge mclk);
        chk("pcs_gig", 16'h000E, {12'h0, pcs_loop_q, ana_loop_q, rev_loop_q, link_ind_q});
        wr(REG_BASIC_CONTROL, 16'h2100);
        repeat (3) @(negedge mclk);
        chk("pcs_100", 16'h000F, {12'h0, pcs_loop_q, ana_loop_q, rev_loop_q, link_ind_q});
        wr(REG_BASIC_CONTROL, 16'h0100);
        repeat (3) @(negedge mclk);
        chk("pcs_10", 16'h0007, {12'h0, pcs_loop_q, ana_loop_q, rev_loop_q, link_ind_q});
    endtask
    task t_straps;
        strap_an_off = 1;
        crossover_auto_off_strap = 1;
        crossover_forced_strap = 1;
        do_reset();
        wr(REG_BASIC_CONTROL, 16'h0140);
        wr(REG_BASIC_CONTROL, 16'h1140);
        rd(REG_BASIC_CONTROL);
        chk("an_locked", 16'h0000, {15'h0, v[12]});
        rd(REG_PHY_SPECIFIC_CONTROL);
        chk("psc_strap", 16'h0020, v & 16'h0060);
        chk("crossed", 16'h0001, {15'h0, crossed_q});
    endtask
    initial begin
        #40000;
        errors++;
        end_of_test();
    end
    initial begin
        do_reset();
        t_reset_pause();
        t_restart_gig();
        t_parallel();
        t_loop();
        t_straps();
        end_of_test();
    end
endmodule
